// *** hdl/flash_burst_cfg.svh ***
`ifndef FLASH_BURST_CFG_SVH
`define FLASH_BURST_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define ADDR_W 22
`define DATA_W 16
`define PIN_W 27

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_CONFIG 8'h00
`define OFF_CONTROL 8'h04
`define OFF_PATTERN 8'h08
`define OFF_STATUS 8'h0c

// ----------------------------------------------------------------
// Read configuration fields and reset values
// ----------------------------------------------------------------
`define CFG_RESET 16'hbfcf
`define CFG_MASK 16'hbfcf
`define CTRL_RESET 1'b1
`define PATTERN_RESET 16'h0000
`define BIT_MODE 15
`define LAT_HI 13
`define LAT_LO 11
`define BIT_POL 10
`define BIT_HOLD 9
`define BIT_WDLY 8
`define BIT_ORDER 7
`define BIT_NOWRAP 3
`define LEN_HI 2
`define LEN_LO 0
`define LEN_4 3'h1
`define LEN_8 3'h2
`define LEN_16 3'h3
`define LEN_CONT 3'h7
`define ROW_MASK 4'hf

`endif

// *** hdl/flash_burst_pkg.sv ***
`include "flash_burst_cfg.svh"

package flash_burst_pkg;

   // ----------------------------------------------------------------
   // Burst sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {st_idle, st_latency, st_burst, st_row_delay, st_done}
      burst_state_type;

   // ----------------------------------------------------------------
   // Whole state of the control block
   // ----------------------------------------------------------------
   typedef struct packed {
      burst_state_type state;
      logic [15:0] cfg;
      logic array_mode;
      logic [`DATA_W-1:0] pattern;
      logic [31:0] prdata;
      logic bclk_prev;
      logic [`ADDR_W-1:0] addr;
      logic [1:0] start_off;
      logic [3:0] cnt;
      logic hold;
      logic [4:0] words_left;
      logic cont;
      logic delay_done;
      logic valid;
      logic [`DATA_W-1:0] dout;
      logic dout_oe;
      logic wait_out;
      logic wait_oe;
   } ctrl_state_type;

endpackage

// *** hdl/pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for a group of pins from outside the clock domain
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pins
   input wire logic [WIDTH-1:0] pins,
   output logic [WIDTH-1:0] pins_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sync_state_type;

   sync_state_type s_q;
   sync_state_type s_d;

   // First stage feeds only the second stage
   always_comb
   begin
      s_d.s1 = pins;
      s_d.s2 = s_q.s1;
   end

   // Pins idle high after reset: enables and strobes are active low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '1;
      else
         s_q <= s_d;
   end

   assign pins_sync = s_q.s2;

endmodule

`default_nettype wire

// *** hdl/flash_burst_read_wait_control.sv ***
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "flash_burst_cfg.svh"

module flash_burst_read_wait_control (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash pins from the burst master
   input wire logic burst_clk,
   input wire logic chip_enable_n,
   input wire logic output_enable_n,
   input wire logic write_enable_n,
   input wire logic address_valid_n,
   input wire logic [`ADDR_W-1:0] address,
   // Flash pins toward the burst master
   output logic [`DATA_W-1:0] data_out,
   output logic data_oe,
   output logic wait_out,
   output logic wait_oe
);

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [`PIN_W-1:0] pins_s;
   logic bclk_s;
   logic ce_n_s;
   logic oe_n_s;
   logic we_n_s;
   logic addr_valid_n_s;
   logic [`ADDR_W-1:0] addr_s;

   pin_sync #(.WIDTH(`PIN_W)) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pins({burst_clk, chip_enable_n, output_enable_n, write_enable_n,
             address_valid_n, address}),
      .pins_sync(pins_s)
   );

   // Unpack the synchronised pin group
   assign {bclk_s, ce_n_s, oe_n_s, we_n_s, addr_valid_n_s, addr_s} = pins_s;

   flash_burst_pkg::ctrl_state_type s_q;
   flash_burst_pkg::ctrl_state_type s_d;

   // ----------------------------------------------------------------
   // Decoded configuration
   // ----------------------------------------------------------------
   logic sync_mode;
   logic no_wrap;
   logic [2:0] lat;
   logic [2:0] len_code;
   logic bclk_rise;
   logic apb_wr;
   logic apb_setup;
   logic [`ADDR_W-1:0] next_addr;
   logic [`ADDR_W-1:0] len_mask;
   logic cross_next;
   logic [3:0] delay_sum;
   logic [3:0] row_delay;
   logic wait_asserted;

   // Config fields and link edge
   assign sync_mode = !s_q.cfg[`BIT_MODE];
   assign no_wrap = s_q.cfg[`BIT_NOWRAP];
   assign lat = s_q.cfg[`LAT_HI:`LAT_LO];
   assign len_code = s_q.cfg[`LEN_HI:`LEN_LO];
   assign bclk_rise = bclk_s && !s_q.bclk_prev;
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pwrite;

   // Length group mask; continuous bursts never wrap
   always_comb
   begin
      if (len_code == `LEN_4)
         len_mask = `ADDR_W'(3);
      else if (len_code == `LEN_8)
         len_mask = `ADDR_W'(7);
      else if (len_code == `LEN_16)
         len_mask = `ADDR_W'(15);
      else
         len_mask = '0;
   end

   // Linear order only: the order bit has no other defined setting
   always_comb
   begin
      if (!no_wrap && !s_q.cont)
         next_addr = (s_q.addr & ~len_mask) | (`ADDR_W'(s_q.addr + 1'b1) & len_mask);
      else
         next_addr = `ADDR_W'(s_q.addr + 1'b1);
   end

   // Row crossing ahead: misaligned start, linear no-wrap or continuous, once only
   assign cross_next = (s_q.state == flash_burst_pkg::st_burst) && !s_q.delay_done
      && (s_q.start_off != 2'h0) && (no_wrap || s_q.cont)
      && (s_q.addr[3:0] == `ROW_MASK) && (s_q.cont || s_q.words_left > 5'd1);

   // Delay grows with the start offset; last word of a group costs latency minus one, never less than one
   assign delay_sum = {1'b0, lat} + {2'b00, s_q.start_off};
   assign row_delay = (delay_sum > 4'd4) ? 4'(delay_sum - 4'd4) : 4'd1;

   // Wait is released only for valid synchronous array data outside writes
   assign wait_asserted = !(sync_mode
      && s_q.array_mode
      && s_q.valid
      && we_n_s
      && !(s_q.cfg[`BIT_WDLY] && cross_next));

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.bclk_prev = bclk_s;

      // APB read data is captured in the setup cycle, unmapped reads give zero
      if (apb_setup)
      begin
         if (paddr == `OFF_CONFIG)
            s_d.prdata = {16'h0000, s_q.cfg};
         else if (paddr == `OFF_CONTROL)
            s_d.prdata = {31'h0, s_q.array_mode};
         else if (paddr == `OFF_PATTERN)
            s_d.prdata = {16'h0000, s_q.pattern};
         else if (paddr == `OFF_STATUS)
            s_d.prdata = {16'h0000, s_q.addr[7:0], 3'h0, s_q.state, s_q.valid,
                          wait_asserted};
         else
            s_d.prdata = 32'h0;
      end

      // APB writes; reserved configuration bits stay zero
      if (apb_wr)
      begin
         if (paddr == `OFF_CONFIG)
            s_d.cfg = pwdata[15:0] & `CFG_MASK;
         else if (paddr == `OFF_CONTROL)
            s_d.array_mode = pwdata[0];
         else if (paddr == `OFF_PATTERN)
            s_d.pattern = pwdata[15:0];
      end

      // Burst sequencer, advanced on each rising edge of the burst clock
      if (ce_n_s || !sync_mode)
      begin
         s_d.state = flash_burst_pkg::st_idle;
         s_d.valid = 1'b0;
         s_d.addr = addr_s;
      end
      else if (bclk_rise)
      begin
         if (!addr_valid_n_s)
         begin
            s_d.state = flash_burst_pkg::st_latency;
            s_d.addr = addr_s;
            s_d.start_off = addr_s[1:0];
            s_d.cnt = {1'b0, lat};
            s_d.valid = 1'b0;
            s_d.delay_done = 1'b0;
            s_d.cont = (len_code != `LEN_4) && (len_code != `LEN_8)
               && (len_code != `LEN_16);
            s_d.words_left = 5'(len_mask) + 5'd1;
         end
         else
         begin
            case (s_q.state)
               flash_burst_pkg::st_latency, flash_burst_pkg::st_row_delay:
               begin
                  if (s_q.cnt <= 4'd1)
                  begin
                     s_d.state = flash_burst_pkg::st_burst;
                     s_d.valid = 1'b1;
                     s_d.hold = s_q.cfg[`BIT_HOLD];
                  end
                  else
                     s_d.cnt = s_q.cnt - 4'd1;
               end
               flash_burst_pkg::st_burst:
               begin
                  if (s_q.hold)
                     s_d.hold = 1'b0;
                  else if ((!s_q.cont && s_q.words_left == 5'd1)
                     || (s_q.cont && &s_q.addr))
                  begin
                     s_d.state = flash_burst_pkg::st_done;
                     s_d.valid = 1'b0;
                  end
                  else
                  begin
                     s_d.addr = next_addr;
                     s_d.words_left = s_q.words_left - 5'd1;
                     s_d.hold = s_q.cfg[`BIT_HOLD];
                     if (cross_next)
                     begin
                        s_d.state = flash_burst_pkg::st_row_delay;
                        s_d.cnt = row_delay;
                        s_d.valid = 1'b0;
                        s_d.delay_done = 1'b1;
                     end
                  end
               end
               default:
                  s_d.valid = 1'b0;
            endcase
         end
      end

      // Pin outputs; asynchronous reads follow the address pins directly
      s_d.dout = (sync_mode ? s_q.addr[`DATA_W-1:0] : addr_s[`DATA_W-1:0]) ^ s_q.pattern;
      s_d.dout_oe = !ce_n_s && !oe_n_s && we_n_s;
      s_d.wait_oe = !ce_n_s;
      s_d.wait_out = wait_asserted ? s_q.cfg[`BIT_POL] : !s_q.cfg[`BIT_POL];
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
         s_q.state <= flash_burst_pkg::st_idle;
         s_q.cfg <= `CFG_RESET;
         s_q.array_mode <= `CTRL_RESET;
         s_q.pattern <= `PATTERN_RESET;
         s_q.bclk_prev <= 1'b1;
         s_q.wait_out <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = s_q.prdata;
   assign pready = psel && penable;
   assign pslverr = psel && penable && (paddr != `OFF_CONFIG) && (paddr != `OFF_CONTROL)
      && (paddr != `OFF_PATTERN) && (paddr != `OFF_STATUS);
   assign data_out = s_q.dout;
   assign data_oe = s_q.dout_oe;
   assign wait_out = s_q.wait_out;
   assign wait_oe = s_q.wait_oe;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_wait_float:
   assert property (@(posedge pclk) disable iff (!presetn)
      ce_n_s |=> !wait_oe)
      else $error("wait driven while chip enable is high");

   a_deassert_valid:
   assert property (@(posedge pclk) disable iff (!presetn)
      (wait_oe && wait_out != $past(s_q.cfg[`BIT_POL])) |-> $past(s_q.valid))
      else $error("wait released without valid data");

   a_async_wait:
   assert property (@(posedge pclk) disable iff (!presetn)
      ($past(s_q.cfg[`BIT_MODE]) && $past(s_q.cfg[`BIT_MODE], 2) && wait_oe)
      |-> wait_out == $past(s_q.cfg[`BIT_POL]))
      else $error("wait not asserted in asynchronous mode");

   a_nonarray_wait:
   assert property (@(posedge pclk) disable iff (!presetn)
      (!$past(s_q.array_mode) && wait_oe) |-> wait_out == $past(s_q.cfg[`BIT_POL]))
      else $error("wait not asserted for non-array read");

   a_write_wait:
   assert property (@(posedge pclk) disable iff (!presetn)
      (!we_n_s && !ce_n_s) |=> (wait_out == $past(s_q.cfg[`BIT_POL])))
      else $error("wait not asserted during write");

   a_two_clock_hold:
   assert property (@(posedge pclk) disable iff (!presetn)
      (bclk_rise && addr_valid_n_s && !ce_n_s && sync_mode
       && s_q.state == flash_burst_pkg::st_burst && s_q.cfg[`BIT_HOLD] && s_q.hold)
      |=> ($stable(s_q.addr) && s_q.state == flash_burst_pkg::st_burst))
      else $error("two-clock hold word changed early");

   a_row_delay_once:
   assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.state != flash_burst_pkg::st_row_delay && s_d.state == flash_burst_pkg::st_row_delay)
      |=> (s_q.delay_done && s_q.start_off != 2'h0 && s_q.addr[3:0] == 4'h0))
      else $error("row delay taken on aligned start or off boundary");

   a_worst_delay:
   assert property (@(posedge pclk) disable iff (!presetn)
      (s_d.state == flash_burst_pkg::st_row_delay && s_q.state == flash_burst_pkg::st_burst
       && s_q.start_off == 2'h3) |=> s_q.cnt == {1'b0, lat} - 4'd1)
      else $error("worst-case row delay not latency minus one");

   a_wrap_group:
   assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.state == flash_burst_pkg::st_burst && !no_wrap && !s_q.cont && len_code == `LEN_4
       && !ce_n_s && sync_mode && addr_valid_n_s)
      |=> s_q.addr[`ADDR_W-1:2] == $past(s_q.addr[`ADDR_W-1:2]))
      else $error("wrapped burst left its group");

   a_early_wait:
   assert property (@(posedge pclk) disable iff (!presetn)
      (cross_next && s_q.cfg[`BIT_WDLY] && wait_oe) |=> wait_out == $past(s_q.cfg[`BIT_POL]))
      else $error("wait not raised a data cycle before row delay");

endmodule

`default_nettype wire

// *** dv/burst_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "flash_burst_cfg.svh"

// Burst master on the far side; its burst clock only runs inside a frame
module burst_host_model (
   // Flash pins toward the block
   output logic burst_clk,
   output logic chip_enable_n,
   output logic output_enable_n,
   output logic write_enable_n,
   output logic address_valid_n,
   output logic [`ADDR_W-1:0] address
);
   // ----------------------------------------------------------------
   // Idle pins
   // ----------------------------------------------------------------
   initial
   begin
      burst_clk = 1'b0;
      chip_enable_n = 1'b1;
      output_enable_n = 1'b1;
      write_enable_n = 1'b1;
      address_valid_n = 1'b1;
      address = '0;
   end

   // ----------------------------------------------------------------
   // One frame: strobe on the first edge, then data clocks
   // ----------------------------------------------------------------
   // The wait pin is never looked at here, so no mask is needed
   task automatic burst(input logic [`ADDR_W-1:0] start, input int edges, input logic wr);
      chip_enable_n = 1'b0;
      output_enable_n = wr;
      write_enable_n = ~wr;
      address_valid_n = 1'b0;
      address = start;
      #40;
      repeat (edges)
      begin
         burst_clk = 1'b1;
         #40;
         burst_clk = 1'b0;
         address_valid_n = 1'b1;
         address = ~address; // Lines hold garbage once the strobe edge is past
         #40;
      end
      chip_enable_n = 1'b1;
      output_enable_n = 1'b1;
      write_enable_n = 1'b1;
      #200;
   endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "flash_burst_cfg.svh"

module tb_top;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic burst_clk, ce_n, oe_n, we_n, addr_valid_n, data_oe, wait_out, wait_oe;
   logic [`ADDR_W-1:0] address;
   logic [`DATA_W-1:0] data_out;
   int fails, num_checks, cycles;
   localparam logic [15:0] PAT = 16'ha5c3;

   flash_burst_read_wait_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .burst_clk(burst_clk), .chip_enable_n(ce_n),
      .output_enable_n(oe_n), .write_enable_n(we_n), .address_valid_n(addr_valid_n),
      .address(address), .data_out(data_out), .data_oe(data_oe), .wait_out(wait_out),
      .wait_oe(wait_oe));

   burst_host_model host (.burst_clk(burst_clk), .chip_enable_n(ce_n),
      .output_enable_n(oe_n), .write_enable_n(we_n), .address_valid_n(addr_valid_n),
      .address(address));

   // ----------------------------------------------------------------
   // Clock and hang guard
   // ----------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // A run of twelve frames needs a few thousand cycles at most
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      if (fails == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Zero-wait slave, but the master still waits for pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Frame of 30 edges; words are taken only while wait is released
   task automatic burst(input logic [15:0] cfg, input logic [21:0] start, input logic wr,
                        input int nexp, input logic fixed, input int ngaps);
      logic [`DATA_W-1:0] got[$];
      logic [21:0] a;
      logic [21:0] m;
      int gaps;
      int pend;
      gaps = 0;
      pend = 0;
      m = cfg[2:0] == 3'h1 ? 22'h3 : cfg[2:0] == 3'h2 ? 22'h7 : 22'hf;
      apb(1'b1, 8'h00, {16'h0000, cfg});
      @(posedge pclk);
      #3;
      fork
         host.burst(start, 30, wr);
         repeat (30)
         begin
            @(posedge burst_clk);
            check("wait enable", wait_oe, 1);
            check("data enable", data_oe, !wr);
            if (wait_out !== cfg[10])
            begin
               gaps += pend;
               pend = 0;
               got.push_back(data_out);
            end
            else if (got.size() > 0)
               pend++;
         end
      join
      for (int i = 0; i < nexp; i++)
      begin
         a = start + 22'(i >> cfg[9]);
         if (!cfg[3] && cfg[2:0] != 3'h7)
            a = (start & ~m) | (a & m);
         check("burst word", 32'(got[i]), 32'(a[15:0] ^ PAT));
      end
      if (fixed)
         check("word count", got.size(), nexp);
      check("delay cycles", gaps, ngaps);
      check("wait float", wait_oe, 0);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic check_regs();
      apb(1'b0, 8'h00, 0);
      check("config reset", rd, 32'h0000bfcf);
      apb(1'b0, 8'h04, 0);
      check("control reset", rd, 32'h00000001);
      apb(1'b1, 8'h10, 32'hffffffff);
      check("unmapped error", err, 1);
      apb(1'b0, 8'h10, 0);
      check("unmapped read", rd, 0);
      apb(1'b1, 8'h08, {16'h0000, PAT});
      apb(1'b0, 8'h08, 0);
      check("pattern", rd, {16'h0000, PAT});
   endtask

   // Order bit is set in every configuration; only linear order exists
   task automatic check_orders();
      burst(16'h1881, 22'h1, 1'b0, 4, 1'b1, 0);
      burst(16'h1c89, 22'h1, 1'b0, 4, 1'b1, 0);
      burst(16'h1882, 22'h5, 1'b0, 8, 1'b1, 0);
      burst(16'h1c83, 22'he, 1'b0, 16, 1'b1, 0);
   endtask

   // Continuous frames cross two rows; only the first crossing may stall
   task automatic check_row_delays();
      burst(16'h1c8f, 22'hc, 1'b0, 20, 1'b0, 0);
      burst(16'h1c8f, 22'he, 1'b0, 20, 1'b0, 1);
      burst(16'h1c8f, 22'hf, 1'b0, 20, 1'b0, 2);
      burst(16'h1d8f, 22'he, 1'b0, 1, 1'b0, 2);
   endtask

   // Two-clock hold, then frames where wait must stay asserted
   task automatic check_held_modes();
      burst(16'h1e81, 22'h2, 1'b0, 8, 1'b1, 0);
      burst(16'h9c81, 22'h1, 1'b0, 0, 1'b1, 0);
      burst(16'h1c81, 22'h1, 1'b1, 0, 1'b1, 0);
      apb(1'b1, 8'h04, 0);
      burst(16'h1881, 22'h1, 1'b0, 0, 1'b1, 0);
      apb(1'b1, 8'h04, 1);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (4)
         @(posedge pclk);
      presetn <= 1'b1;
      check_regs();
      check_orders();
      check_row_delays();
      check_held_modes();
      report_and_stop();
   end
endmodule
`default_nettype wire
